// >>> rtl/cls_pkg.sv
package cls_pkg;
	// cluster geometry
	localparam int NSLICE = 4;
	localparam int LUT_IN = 4;
	localparam int TBL_W  = 16;
	localparam int ADDR_W = 8;
	localparam int CTL_W  = 17;
	// register map: per-slice block at slice index times the stride
	localparam logic [3:0] OFF_TBL_FIRST  = 4'h0;
	localparam logic [3:0] OFF_TBL_SECOND = 4'h4;
	localparam logic [3:0] OFF_CTL        = 4'h8;
	localparam logic [7:0] OFF_GLOBAL     = 8'h40;
	localparam logic [7:0] OFF_STATUS     = 8'h44;
	localparam int SLC_LSB = 4;
	localparam int RGN_LSB = 6;
	localparam logic [1:0] RGN_SLICE = 2'h0;
	// control register fields
	localparam int CTL_MODE_FIRST  = 0;
	localparam int CTL_MODE_SECOND = 2;
	localparam int CTL_LATCH       = 4;
	localparam int CTL_DSEL_FIRST  = 5;
	localparam int CTL_DSEL_SECOND = 6;
	localparam int CTL_SETS_TO_ONE = 7;
	localparam int CTL_POWER_UP_ONE = 8;
	localparam int CTL_INIT_INDEP  = 9;
	localparam int CTL_SYNC_SR     = 10;
	localparam int CTL_SR_USED     = 11;
	localparam int CTL_CE_USED     = 12;
	localparam int CTL_CLK_INV     = 13;
	localparam int CTL_CE_INV      = 14;
	localparam int CTL_SR_INV      = 15;
	localparam int CTL_CHAIN       = 16;
	localparam int GLB_INIT        = 0;
	localparam logic [CTL_W-1:0] CTL_RESET = 17'h00400;
	localparam logic [TBL_W-1:0] TBL_RESET = 16'h0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// function generator modes
	typedef enum logic [1:0] {
		FG_LUT   = 2'h0,
		FG_RAM   = 2'h1,
		FG_SHIFT = 2'h2
	} cls_fgmode_t;
endpackage : cls_pkg

// >>> rtl/cls_cluster.sv
`timescale 1ns/1ps
module cls_cluster
	import cls_pkg::*;
(
	// clock, freeze and reset
	input  wire logic                 mclk,
	input  wire logic                 mclkEn,
	input  wire logic                 nrst,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// fabric inputs, four bits per slice for the generator inputs
	input  wire logic [4*NSLICE-1:0]  lutInFirst,
	input  wire logic [4*NSLICE-1:0]  lutInSecond,
	input  wire logic [NSLICE-1:0]    directInputFirst,
	input  wire logic [NSLICE-1:0]    directInputSecond,
	input  wire logic [NSLICE-1:0]    sliceClk,
	input  wire logic [NSLICE-1:0]    sliceCe,
	input  wire logic [NSLICE-1:0]    sliceSetReset,
	// chains entering the cluster
	input  wire logic [1:0]           carryIn,
	input  wire logic                 shiftIn,
	input  wire logic                 wideIn,
	// fabric outputs
	output logic [NSLICE-1:0]         lutOutFirst,
	output logic [NSLICE-1:0]         lutOutSecond,
	output logic [NSLICE-1:0]         sumOutFirst,
	output logic [NSLICE-1:0]         sumOutSecond,
	output logic [NSLICE-1:0]         storeOutFirst,
	output logic [NSLICE-1:0]         storeOutSecond,
	output logic [NSLICE-1:0]         wideMuxFive,
	output logic [NSLICE-1:0]         wideMuxUpper,
	output logic [1:0]                carryOut,
	output logic                      shiftOut
);

	// byte-lane merge for register writes
	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = dat[8*b +: 8];
		end
		return res;
	endfunction : mergeStrb

	// configuration and generator contents
	logic [CTL_W-1:0] ctl_q   [NSLICE];   // per-slice control
	logic [TBL_W-1:0] tblF_q  [NSLICE];   // first generator contents
	logic [TBL_W-1:0] tblG_q  [NSLICE];   // second generator contents
	logic [1:0]       store_q [NSLICE];   // {second, first} storage
	logic [NSLICE:0]  shiftLink;          // shift chain through slices
	logic [NSLICE-1:0] carryMid;          // carry between generators
	logic [NSLICE-1:0] carryInSlice;      // carry into each slice
	logic [1:0]        lowCarry;          // carry out of the lower slice per column

	// write channel state
	logic              awHave_q;          // address held
	logic [ADDR_W-1:0] awAddr_q;
	logic              wHave_q;           // data held
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              bValid_q;
	logic [1:0]        bResp_q;
	logic              wrFire;            // both halves present, apply now
	logic              wrInSlice;
	logic [1:0]        wrSlice;
	logic [3:0]        wrReg;
	logic              wrMapped;
	// read channel state
	logic              rValid_q;
	logic [31:0]       rData_q;
	logic [1:0]        rResp_q;
	logic [31:0]       rdWord;
	logic              rdMapped;
	// initialisation
	logic              initPend_q;        // loads initial state after reset
	logic              initLoad;

	// no new request while a response waits; freeze also stalls the bus
	assign s_axi_awready = mclkEn & ~awHave_q & ~bValid_q;
	assign s_axi_wready  = mclkEn & ~wHave_q & ~bValid_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = mclkEn & ~rValid_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;

	// write decode on the held address
	assign wrFire    = awHave_q & wHave_q & ~bValid_q;
	assign wrInSlice = (awAddr_q[ADDR_W-1:RGN_LSB] == RGN_SLICE);
	assign wrSlice   = awAddr_q[RGN_LSB-1:SLC_LSB];
	assign wrReg     = awAddr_q[SLC_LSB-1:0];
	assign wrMapped  = (wrInSlice & (wrReg == OFF_TBL_FIRST | wrReg == OFF_TBL_SECOND | wrReg == OFF_CTL))
		| (awAddr_q == OFF_GLOBAL) | (awAddr_q == OFF_STATUS);

	// write channel: address and data taken in either order
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			awHave_q <= 1'b0;
			awAddr_q <= '0;
			wHave_q  <= 1'b0;
			wData_q  <= '0;
			wStrb_q  <= '0;
			bValid_q <= 1'b0;
			bResp_q  <= RESP_OKAY;
		end
		else if (mclkEn)
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrFire)
			begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bValid_q & s_axi_bready)
				bValid_q <= 1'b0;
		end
	end

	// read mux: tables read back live, so ram and shift contents show
	always_comb
	begin
		rdWord   = '0;
		rdMapped = 1'b1;
		if (s_axi_araddr[ADDR_W-1:RGN_LSB] == RGN_SLICE)
		begin
			unique case (s_axi_araddr[SLC_LSB-1:0])
				OFF_TBL_FIRST:  rdWord[TBL_W-1:0] = tblF_q[s_axi_araddr[RGN_LSB-1:SLC_LSB]];
				OFF_TBL_SECOND: rdWord[TBL_W-1:0] = tblG_q[s_axi_araddr[RGN_LSB-1:SLC_LSB]];
				OFF_CTL:        rdWord[CTL_W-1:0] = ctl_q[s_axi_araddr[RGN_LSB-1:SLC_LSB]];
				default:        rdMapped = 1'b0;
			endcase
		end
		else if (s_axi_araddr == OFF_STATUS)
		begin
			for (int k = 0; k < NSLICE; k++)
				rdWord[2*k +: 2] = store_q[k];
		end
		else if (s_axi_araddr != OFF_GLOBAL)
			rdMapped = 1'b0;
	end

	// read channel: data one cycle after the address is taken
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rValid_q <= 1'b0;
			rData_q  <= '0;
			rResp_q  <= RESP_OKAY;
		end
		else if (mclkEn)
		begin
			if (s_axi_arvalid & s_axi_arready)
			begin
				rValid_q <= 1'b1;
				rData_q  <= rdWord;
				rResp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rValid_q & s_axi_rready)
				rValid_q <= 1'b0;
		end
	end

	// initial state is loaded after reset and on a global init write
	assign initLoad = initPend_q | (wrFire & (awAddr_q == OFF_GLOBAL) & wStrb_q[0] & wData_q[GLB_INIT]);

	// pending flag keeps reset itself constant-only
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			initPend_q <= 1'b1;
		else if (mclkEn)
			initPend_q <= 1'b0;
	end

	// chain ends: two columns of carry, one shift chain
	assign shiftLink[0]    = shiftIn;
	assign shiftOut        = shiftLink[NSLICE];
	assign carryInSlice[0] = carryIn[0];
	assign carryInSlice[1] = lowCarry[0];     // feeding the column's own output back would loop
	assign carryInSlice[2] = carryIn[1];
	assign carryInSlice[3] = lowCarry[1];

	genvar s;
	generate
		for (s = 0; s < NSLICE; s++)
		begin : g_slice
			logic [LUT_IN-1:0] idxF;
			logic [LUT_IN-1:0] idxG;
			logic        clkLvl;       // slice clock after polarity
			logic        clkLvl_q;
			logic        clkEdge;
			logic        ceAct;
			logic        srRaw;        // polarity-corrected set/reset
			logic        srAct;
			logic        byAct;
			logic        forceZero;
			logic        forceOne;
			logic        clockTime;    // edge for flops, level for latches
			logic        srTake;
			logic        initVal;
			logic        lutPathFirst;
			logic        lutPathSecond;
			logic [1:0]  dIn;
			logic        openGate;
			logic        shInF;
			logic        forceNow;     // force shows at the output this cycle
			cls_fgmode_t modeF;
			cls_fgmode_t modeG;

			assign idxF  = lutInFirst[4*s +: 4];
			assign idxG  = lutInSecond[4*s +: 4];
			assign modeF = cls_fgmode_t'(ctl_q[s][CTL_MODE_FIRST +: 2]);
			assign modeG = cls_fgmode_t'(ctl_q[s][CTL_MODE_SECOND +: 2]);

			// controls shared by both storage elements; clock, ce and set/reset each with its own inversion, bypass force uninverted
			assign clkLvl  = sliceClk[s] ^ ctl_q[s][CTL_CLK_INV];
			assign clkEdge = clkLvl & ~clkLvl_q;
			assign ceAct   = ~ctl_q[s][CTL_CE_USED] | (sliceCe[s] ^ ctl_q[s][CTL_CE_INV]);
			assign srRaw   = sliceSetReset[s] ^ ctl_q[s][CTL_SR_INV];
			assign srAct   = ctl_q[s][CTL_SR_USED] & srRaw;
			assign byAct   = ctl_q[s][CTL_SR_USED] & directInputSecond[s];
			// the sets-to-zero case is the clear attribute bit
			assign forceZero = ctl_q[s][CTL_SETS_TO_ONE] ? byAct : srAct;
			assign forceOne  = ctl_q[s][CTL_SETS_TO_ONE] ? srAct : byAct;
			assign clockTime = ctl_q[s][CTL_LATCH] ? clkLvl : clkEdge;
			assign srTake    = ~ctl_q[s][CTL_SYNC_SR] | clockTime;
			assign initVal   = ctl_q[s][CTL_INIT_INDEP] ? ctl_q[s][CTL_POWER_UP_ONE]
				: ctl_q[s][CTL_SETS_TO_ONE];

			// function generators: table lookup, delay same for any function
			assign lutOutFirst[s]  = tblF_q[s][idxF];
			assign lutOutSecond[s] = tblG_q[s][idxG];
			// five-input mux picks between the two generators
			assign wideMuxFive[s]  = directInputFirst[s] ? lutOutFirst[s] : lutOutSecond[s];
			// carry mux and dedicated xor per generator
			assign carryMid[s]     = lutOutFirst[s] ? carryInSlice[s] : directInputFirst[s];
			assign sumOutFirst[s]  = lutOutFirst[s] ^ carryInSlice[s];
			assign sumOutSecond[s] = lutOutSecond[s] ^ carryMid[s];

			// store data from generator path or bypass input
			assign lutPathFirst  = lutOutFirst[s];
			assign lutPathSecond = lutOutSecond[s];
			assign dIn[0] = ctl_q[s][CTL_DSEL_FIRST] ? directInputFirst[s] : lutPathFirst;
			assign dIn[1] = ctl_q[s][CTL_DSEL_SECOND] ? directInputSecond[s] : lutPathSecond;

			// latch outputs are transparent, async forces show at once
			assign openGate = ctl_q[s][CTL_LATCH] & clkLvl & ceAct;
			// a synchronous force on an open latch must not let the data through
			assign forceNow = ~ctl_q[s][CTL_SYNC_SR] | (ctl_q[s][CTL_LATCH] & clkLvl);
			always_comb
			begin
				if (forceNow & forceZero)
					{storeOutSecond[s], storeOutFirst[s]} = 2'h0;
				else if (forceNow & forceOne)
					{storeOutSecond[s], storeOutFirst[s]} = 2'h3;
				else if (openGate)
					{storeOutSecond[s], storeOutFirst[s]} = dIn;
				else
					{storeOutSecond[s], storeOutFirst[s]} = store_q[s];
			end

			// shift data enters from the previous slice when chained
			assign shInF            = ctl_q[s][CTL_CHAIN] ? shiftLink[s] : directInputFirst[s];
			assign shiftLink[s + 1] = tblG_q[s][TBL_W-1];

			// slice clock edge detect, fabric drives it on mclk
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					clkLvl_q <= 1'b0;
				else if (mclkEn)
					clkLvl_q <= clkLvl;
			end

			// control register
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					ctl_q[s] <= CTL_RESET;
				else if (mclkEn & wrFire & wrInSlice & (wrSlice == s) & (wrReg == OFF_CTL))
					ctl_q[s] <= CTL_W'(mergeStrb(32'(ctl_q[s]), wData_q, wStrb_q));
			end

			// storage pair: init, then reset-over-set, then data
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					store_q[s] <= 2'h0;
				else if (mclkEn)
				begin
					if (initLoad)
						store_q[s] <= {initVal, initVal};
					else if (srTake & forceZero)
						store_q[s] <= 2'h0;
					else if (srTake & forceOne)
						store_q[s] <= 2'h3;
					else if (ceAct & clockTime)
						store_q[s] <= dIn;
				end
			end

			// first generator: software load, ram write or shift
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					tblF_q[s] <= TBL_RESET;
				else if (mclkEn)
				begin
					if (wrFire & wrInSlice & (wrSlice == s) & (wrReg == OFF_TBL_FIRST))
						tblF_q[s] <= TBL_W'(mergeStrb(32'(tblF_q[s]), wData_q, wStrb_q));
					else if (clkEdge & ceAct)
					begin
						unique case (modeF)
							FG_RAM:   if (srRaw) tblF_q[s][idxF] <= directInputFirst[s];
							FG_SHIFT: tblF_q[s] <= {tblF_q[s][TBL_W-2:0], shInF};
							default:  ;
						endcase
					end
				end
			end

			// second generator: cascades from the first when shifting
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					tblG_q[s] <= TBL_RESET;
				else if (mclkEn)
				begin
					if (wrFire & wrInSlice & (wrSlice == s) & (wrReg == OFF_TBL_SECOND))
						tblG_q[s] <= TBL_W'(mergeStrb(32'(tblG_q[s]), wData_q, wStrb_q));
					else if (clkEdge & ceAct)
					begin
						unique case (modeG)
							FG_RAM:   if (srRaw) tblG_q[s][idxG] <= directInputSecond[s];
							FG_SHIFT: tblG_q[s] <= {tblG_q[s][TBL_W-2:0], tblF_q[s][TBL_W-1]};
							default:  ;
						endcase
					end
				end
			end
		end
	endgenerate

	// column carry outputs
	assign carryOut[0] = lutOutSecond[1] ? carryMid[1] : directInputSecond[1];
	assign carryOut[1] = lutOutSecond[3] ? carryMid[3] : directInputSecond[3];
	// carry out of the lower slice in each column, into the upper one
	assign lowCarry[0] = lutOutSecond[0] ? carryMid[0] : directInputSecond[0];
	assign lowCarry[1] = lutOutSecond[2] ? carryMid[2] : directInputSecond[2];

	// upper mux role set by slice position: six, seven, six, eight
	assign wideMuxUpper[0] = directInputSecond[0] ? wideMuxFive[0] : wideMuxFive[1];
	assign wideMuxUpper[2] = directInputSecond[2] ? wideMuxFive[2] : wideMuxFive[3];
	assign wideMuxUpper[1] = directInputSecond[1] ? wideMuxUpper[0] : wideMuxUpper[2];
	assign wideMuxUpper[3] = directInputSecond[3] ? wideMuxUpper[1] : wideIn;

endmodule : cls_cluster

// >>> verification/cls_cluster_chk.sv
`timescale 1ns/1ps
module cls_cluster_chk
	import cls_pkg::*;
(
	// clock, freeze and reset
	input wire logic              mclk,
	input wire logic              mclkEn,
	input wire logic              nrst,
	// bus handshakes and answers
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// fabric selects and outputs
	input wire logic [NSLICE-1:0] directInputFirst,
	input wire logic [NSLICE-1:0] directInputSecond,
	input wire logic              wideIn,
	input wire logic [NSLICE-1:0] lutOutFirst,
	input wire logic [NSLICE-1:0] lutOutSecond,
	input wire logic [NSLICE-1:0] wideMuxFive,
	input wire logic [NSLICE-1:0] wideMuxUpper
);
	// one clock domain, so one clocking and one reset for all
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// a pending read answer blocks the next address
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address accepted with answer pending");
	// read answer and its data stand until taken
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed before taken");
	// write response stands until taken
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response changed before taken");
	// read answers one cycle after the address is taken
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	// no new write while a response waits
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write accepted with response pending");
	// freeze drops every ready
	property p_freeze; !mclkEn |-> !(s_axi_awready || s_axi_wready || s_axi_arready); endproperty
	a_freeze: assert property (p_freeze) else $error("ready high while frozen");
	// five-input mux picks first or second generator per slice
	property p_wide_five; wideMuxFive == ((directInputFirst & lutOutFirst) | (~directInputFirst & lutOutSecond)); endproperty
	a_wide_five: assert property (p_wide_five) else $error("five-input mux wrong");
	// upper muxes chain by position in the cluster
	property p_wide_upper; wideMuxUpper[0] == (directInputSecond[0] ? wideMuxFive[0] : wideMuxFive[1])
		&& wideMuxUpper[2] == (directInputSecond[2] ? wideMuxFive[2] : wideMuxFive[3])
		&& wideMuxUpper[1] == (directInputSecond[1] ? wideMuxUpper[0] : wideMuxUpper[2])
		&& wideMuxUpper[3] == (directInputSecond[3] ? wideMuxUpper[1] : wideIn); endproperty
	a_wide_upper: assert property (p_wide_upper) else $error("upper mux wrong");
endmodule : cls_cluster_chk

bind cls_cluster cls_cluster_chk cls_cluster_chk_i (.mclk, .mclkEn, .nrst, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .directInputFirst, .directInputSecond, .wideIn, .lutOutFirst, .lutOutSecond,
	.wideMuxFive, .wideMuxUpper);

// >>> verification/cls_cluster_tb.sv
`timescale 1ns/1ps
module cls_cluster_tb;
	import cls_pkg::*;
	// clock, reset and bus
	logic              mclk, mclkEn, nrst;
	logic [7:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, d;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	// fabric side
	logic [15:0]       lutInFirst, lutInSecond;
	logic [NSLICE-1:0] directInputFirst, directInputSecond, sliceClk, sliceCe, sliceSetReset;
	logic [NSLICE-1:0] lutOutFirst, lutOutSecond, sumOutFirst, sumOutSecond, storeOutFirst, storeOutSecond;
	logic [NSLICE-1:0] wideMuxFive, wideMuxUpper;
	logic [1:0]        carryIn, carryOut;
	logic              shiftIn, wideIn, shiftOut;
	// model tables and tallies
	logic [15:0]       tf [NSLICE];
	logic [15:0]       tg [NSLICE];
	int                n_fail, comparisons;
	// latch steps: slice clock, data, expected store
	localparam logic [2:0] LAT [6] = '{3'b111, 3'b100, 3'b000, 3'b010, 3'b111, 3'b001};

	cls_cluster cls_cluster_i (.mclk, .mclkEn, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.lutInFirst, .lutInSecond, .directInputFirst, .directInputSecond, .sliceClk, .sliceCe, .sliceSetReset,
		.carryIn, .shiftIn, .wideIn, .lutOutFirst, .lutOutSecond, .sumOutFirst, .sumOutSecond, .storeOutFirst,
		.storeOutSecond, .wideMuxFive, .wideMuxUpper, .carryOut, .shiftOut);

	// free-running 10 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one write; bready held back so the response has to wait unless held only one cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		repeat (1 + $urandom % 3) @(posedge mclk);
		s_axi_bready <= 1'b1;
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// one read; rready sometimes late to stall the answer
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge mclk);
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// one slice clock pulse, seen as an edge on the next mclk
	task automatic pulse(input int s);
		sliceClk[s] <= 1'b1;
		repeat (2) @(posedge mclk);
		sliceClk[s] <= 1'b0;
		@(posedge mclk);
	endtask : pulse

	// generator outputs and wide muxes against the model tables
	task automatic lut_check();
		logic [NSLICE-1:0] ef, eg, e5, eu, ci, cm, co;
		// carry climbs each column: slice 0 into 1, slice 2 into 3
		for (int s = 0; s < NSLICE; s++)
		begin
			ef[s] = tf[s][lutInFirst[4*s +: 4]];
			eg[s] = tg[s][lutInSecond[4*s +: 4]];
			ci[s] = (s % 2 == 1) ? co[s - 1] : carryIn[s / 2];
			cm[s] = ef[s] ? ci[s] : directInputFirst[s];
			co[s] = eg[s] ? cm[s] : directInputSecond[s];
		end
		chk("sumFirst", 32'(ef ^ ci), 32'(sumOutFirst));
		chk("sumSecond", 32'(eg ^ cm), 32'(sumOutSecond));
		chk("carryOut", 32'({co[3], co[1]}), 32'(carryOut));
		chk("shiftOut", 32'(tg[3][15]), 32'(shiftOut));
		e5 = (directInputFirst & ef) | (~directInputFirst & eg);
		eu[0] = directInputSecond[0] ? e5[0] : e5[1];
		eu[2] = directInputSecond[2] ? e5[2] : e5[3];
		eu[1] = directInputSecond[1] ? eu[0] : eu[2];
		eu[3] = directInputSecond[3] ? eu[1] : wideIn;
		chk("lutFirst", 32'(ef), 32'(lutOutFirst));
		chk("lutSecond", 32'(eg), 32'(lutOutSecond));
		chk("muxFive", 32'(e5), 32'(wideMuxFive));
		chk("muxUpper", 32'(eu), 32'(wideMuxUpper));
	endtask : lut_check

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// whole run is a few hundred cycles; this is about a hundred times that
	initial
	begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		give_verdict();
	end

	initial
	begin
		{mclkEn, nrst, s_axi_wstrb} = 6'h2F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, carryIn, shiftIn, wideIn} = '0;
		{lutInFirst, lutInSecond, directInputFirst, directInputSecond, sliceClk, sliceCe, sliceSetReset} = '0;
		n_fail = 0;
		comparisons = 0;
		void'($urandom(19067));
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		// reset values, then random tables into every generator
		for (int s = 0; s < NSLICE; s++)
		begin
			rd(8'(s * 16 + OFF_CTL));
			chk("ctlReset", 32'(CTL_RESET), d);
			rd(8'(s * 16));
			chk("tblReset", 32'(TBL_RESET), d);
			tf[s] = 16'($urandom);
			tg[s] = 16'($urandom);
			wr(8'(s * 16), {16'h0, tf[s]});
			wr(8'(s * 16 + OFF_TBL_SECOND), {16'h0, tg[s]});
		end
		// unmapped and read-only places
		rd(8'h0C);
		chk("gapResp", 32'(RESP_SLVERR), 32'(r));
		chk("gapData", 32'h0, d);
		wr(8'h44, 32'hFFFF_FFFF);
		chk("roResp", 32'(RESP_OKAY), 32'(r));
		rd(8'h48);
		chk("farResp", 32'(RESP_SLVERR), 32'(r));
		// random lookups through both generators and the wide muxes
		repeat (24)
		begin
			{lutInFirst, lutInSecond, directInputFirst, directInputSecond, wideIn, carryIn} <= 43'({$urandom, $urandom});
			@(posedge mclk);
			lut_check();
		end
		// slice 0 shifts both generators, ce unused so always enabled
		wr(8'h08, 32'h0000_000A);
		repeat (10)
		begin
			directInputFirst[0] <= 1'($urandom);
			pulse(0);
			tg[0] = {tg[0][14:0], tf[0][15]};
			tf[0] = {tf[0][14:0], directInputFirst[0]};
			lut_check();
		end
		// slice 2 first generator as memory, written on the slice edge
		wr(8'h28, 32'h0000_0001);
		sliceSetReset[2] <= 1'b1;
		repeat (4)
		begin
			{lutInFirst[11:8], directInputFirst[2]} <= 5'($urandom);
			pulse(2);
			tf[2][lutInFirst[11:8]] = directInputFirst[2];
			lut_check();
		end
		sliceSetReset[2] <= 1'b0;
		// slice 1: first store on direct data, second on its generator, sets to one, set/reset used, asynchronous
		wr(8'h18, 32'h0000_08A0);
		{sliceSetReset[1], directInputSecond[1]} <= 2'b10;
		repeat (2) @(posedge mclk);
		chk("setOne", 32'h3, 32'({storeOutSecond[1], storeOutFirst[1]}));
		{sliceSetReset[1], directInputSecond[1]} <= 2'b01;
		repeat (2) @(posedge mclk);
		chk("opposite", 32'h0, 32'({storeOutSecond[1], storeOutFirst[1]}));
		{sliceSetReset[1], directInputSecond[1]} <= 2'b10;
		repeat (2) @(posedge mclk);
		chk("setAgain", 32'h3, 32'({storeOutSecond[1], storeOutFirst[1]}));
		{sliceSetReset[1], directInputSecond[1]} <= 2'b11;
		repeat (2) @(posedge mclk);
		chk("resetWins", 32'h0, 32'({storeOutSecond[1], storeOutFirst[1]}));
		{sliceSetReset[1], directInputSecond[1]} <= 2'b00;
		repeat (4)
		begin
			directInputFirst[1] <= 1'($urandom);
			pulse(1);
			chk("dataDirect", 32'(directInputFirst[1]), 32'(storeOutFirst[1]));
			chk("dataLut", 32'(tg[1][lutInSecond[7:4]]), 32'(storeOutSecond[1]));
		end
		// latch: passes while slice clock high, holds while low
		wr(8'h18, 32'h0000_08B0);
		for (int i = 0; i < 6; i++)
		begin
			{sliceClk[1], directInputFirst[1]} <= LAT[i][2:1];
			repeat (2) @(posedge mclk);
			chk("latch", 32'(LAT[i][0]), 32'(storeOutFirst[1]));
		end
		// ce in use and low blocks capture; inverting it enables
		wr(8'h18, 32'h0000_18A0);
		pulse(1);
		chk("ceLow", 32'h1, 32'(storeOutFirst[1]));
		wr(8'h18, 32'h0000_58A0);
		pulse(1);
		chk("ceInv", 32'h0, 32'(storeOutFirst[1]));
		// initial state: independent power-up one, then following sets to zero
		wr(8'h18, 32'h0000_5BA0);
		wr(OFF_GLOBAL, 32'h1);
		rd(OFF_STATUS);
		chk("initOne", 32'h0000_000C, d);
		wr(8'h18, 32'h0000_5820);
		wr(OFF_GLOBAL, 32'h1);
		chk("initZero", 32'h0, 32'({storeOutSecond[1], storeOutFirst[1]}));
		// synchronous set/reset waits for the slice edge
		wr(8'h18, 32'h0000_5C20);
		directInputFirst[1] <= 1'b1;
		pulse(1);
		sliceSetReset[1] <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("syncWait", 32'h1, 32'(storeOutFirst[1]));
		pulse(1);
		chk("syncZero", 32'h0, 32'(storeOutFirst[1]));
		// brief freeze: bus refuses and a slice clock pulse must not shift
		mclkEn <= 1'b0;
		pulse(0);
		chk("frozenReady", 32'h0, 32'({s_axi_awready, s_axi_wready, s_axi_arready}));
		mclkEn <= 1'b1;
		@(posedge mclk);
		lut_check();
		give_verdict();
	end
endmodule : cls_cluster_tb
